// file: hdl/fprf_top.sv
`timescale 1ns/1ps
`include "fprf_regs.svh"
module fprf_top #(
  parameter int unsigned LEVEL   = 4,
  parameter logic [7:0]  IMPL_ID = 8'h5a, // arbitrary value
  parameter logic [7:0]  REV_ID  = 8'h01  // arbitrary value
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 model64_sel,
  input  wire logic                 xfer_valid,
  input  wire fprf_pkg::fprf_xop_t  xfer_op,
  input  wire logic [4:0]           xfer_reg,
  input  wire logic [63:0]          xfer_wdata,
  input  wire logic                 op_valid,
  input  wire fprf_pkg::fprf_tag_t  op_src_fmt,
  input  wire fprf_pkg::fprf_tag_t  op_res_fmt,
  input  wire logic [4:0]           op_src_a,
  input  wire logic [4:0]           op_src_b,
  input  wire logic                 op_src_b_used,
  input  wire logic [4:0]           op_dst,
  input  wire logic [63:0]          op_result,
  input  wire logic [5:0]           op_cause,
  input  wire logic                 op_denorm,
  input  wire logic                 cmp_valid,
  input  wire logic [2:0]           cmp_cc,
  input  wire logic                 cmp_true,
  input  wire logic [2:0]           br_cc,
  output logic [63:0]               xfer_rdata_r,
  output logic                      xfer_done_r,
  output logic                      xfer_illegal_r,
  output logic                      trap_r,
  output logic                      flush_to_zero_r,
  output fprf_pkg::fprf_round_t     rounding_select_r,
  output logic                      res_unknown_r,
  output logic                      br_taken_r
);

  // ****************************************************************
  //  decode and checks
  // ****************************************************************
  generate
    if (LEVEL < 1 || LEVEL > 4) begin : g_bad_level
      $error("fprf_top: LEVEL must be 1 to 4");
    end
  endgenerate

  logic [31:0]          cs_r;
  logic [31:0]          cs_nxt;
  logic [63:0]          gr_r [32];
  fprf_pkg::fprf_tag_t  tag_r [32];
  logic                 m64;
  logic                 x_dw;
  logic                 x_rd;
  logic                 x_mv;
  logic                 x_ct;
  logic                 x_bad;
  logic                 x_wr;
  logic [4:0]           x_even;
  logic [4:0]           x_odd;
  logic [4:0]           x_tix;

  // 64-bit model only exists from level 3 upward
  assign m64    = (LEVEL >= 3) && model64_sel;
  assign x_ct   = xfer_op[3];
  assign x_mv   = xfer_op[2];
  assign x_dw   = !x_ct && xfer_op[1];
  assign x_rd   = xfer_op[0];
  assign x_even = {xfer_reg[4:1], 1'b0};
  assign x_odd  = {xfer_reg[4:1], 1'b1};
  assign x_tix  = m64 ? xfer_reg : x_even;

  // refused transfers: level and model limits, odd pair base, unknown control reg, undefined opcodes
  always_comb begin
    x_bad = 1'b0;
    if (x_dw && LEVEL < 2)
      x_bad = 1'b1;
    if (x_dw && x_mv && !m64)
      x_bad = 1'b1;
    if (x_dw && !m64 && xfer_reg[0])
      x_bad = 1'b1;
    if (x_ct && xfer_reg != `FPRF_CREG_ID && xfer_reg != `FPRF_CREG_CSR)
      x_bad = 1'b1;
    if (xfer_op[3:1] == 3'b101 || xfer_op[3:1] == 3'b110 || xfer_op[3:1] == 3'b111)
      x_bad = 1'b1;
  end

  assign x_wr = xfer_valid && !x_bad && !x_rd && !x_ct;

  // ****************************************************************
  //  general register write port
  // ****************************************************************
  // an operation owns the port; the core never issues both together
  logic        wp_en;
  logic [4:0]  wp_idx;
  logic        wp_pair;
  logic        wp_wide;
  logic [63:0] wp_d;
  logic        op_fmt64;

  assign op_fmt64 = (op_res_fmt == fprf_pkg::FPRF_FMT_D) ||
                    (op_res_fmt == fprf_pkg::FPRF_FMT_L);

  always_comb begin
    wp_en   = 1'b0;
    wp_idx  = xfer_reg;
    wp_pair = 1'b0;
    wp_wide = 1'b0;
    wp_d    = xfer_wdata;
    if (op_valid) begin
      wp_en   = 1'b1;
      wp_idx  = m64 ? op_dst : {op_dst[4:1], 1'b0};
      wp_pair = !m64 && op_fmt64;
      wp_wide = m64 && op_fmt64;
      wp_d    = op_denorm && cs_r[`FPRF_CSR_FZ_BIT] ? 64'h0000_0000_0000_0000 : op_result;
    end else if (x_wr) begin
      wp_en   = 1'b1;
      wp_idx  = x_dw && !m64 ? x_even : xfer_reg;
      wp_pair = x_dw && !m64;
      wp_wide = x_dw && m64;
    end
  end

  // one entry per general register; the odd half of a pair gets the high word
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_gr
      logic lo_we;
      logic hi_we;
      assign lo_we = wp_en && (wp_idx == 5'(gi) || (wp_pair && (wp_idx | 5'h01) == 5'(gi)));
      assign hi_we = wp_en && wp_wide && wp_idx == 5'(gi);
      always_ff @(posedge sys_clk) begin
        if (lo_we)
          gr_r[gi][31:0] <= (wp_pair && gi % 2 == 1) ? wp_d[63:32] : wp_d[31:0];
        if (hi_we)
          gr_r[gi][63:32] <= wp_d[63:32];
      end
    end
  endgenerate

  // ****************************************************************
  //  operand format tags
  // ****************************************************************
  logic [4:0] ta_ix;
  logic [4:0] tb_ix;
  logic       a_bad;
  logic       b_bad;
  logic       res_unk;

  assign ta_ix   = m64 ? op_src_a : {op_src_a[4:1], 1'b0};
  assign tb_ix   = m64 ? op_src_b : {op_src_b[4:1], 1'b0};
  assign a_bad   = tag_r[ta_ix] != fprf_pkg::FPRF_UNINT && tag_r[ta_ix] != op_src_fmt;
  assign b_bad   = op_src_b_used && tag_r[tb_ix] != fprf_pkg::FPRF_UNINT &&
                   tag_r[tb_ix] != op_src_fmt;
  assign res_unk = a_bad || b_bad;

  // a source either takes the format it is read as or turns unknown
  function automatic fprf_pkg::fprf_tag_t src_tag(fprf_pkg::fprf_tag_t t,
                                                  fprf_pkg::fprf_tag_t f);
    if (t == fprf_pkg::FPRF_UNINT)
      return f;
    else if (t == f)
      return t;
    else
      return fprf_pkg::FPRF_UNKN;
  endfunction

  // later assignments win: destination over sources, as an op writes last
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++)
        tag_r[i] <= fprf_pkg::FPRF_UNINT;
    end else if (op_valid) begin
      tag_r[ta_ix] <= src_tag(tag_r[ta_ix], op_src_fmt);
      if (op_src_b_used)
        tag_r[tb_ix] <= src_tag(tag_r[tb_ix], op_src_fmt);
      tag_r[wp_idx] <= res_unk ? fprf_pkg::FPRF_UNKN : op_res_fmt;
    end else if (x_wr) begin
      tag_r[x_tix] <= fprf_pkg::FPRF_UNINT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst)
      res_unknown_r <= 1'b0;
    else
      res_unknown_r <= op_valid && res_unk;
  end

  // ****************************************************************
  //  control/status register
  // ****************************************************************
  logic [5:0] eff_cause;
  logic       op_trap;
  logic       csr_wr;

  assign csr_wr = xfer_valid && !x_bad && x_ct && !x_rd && xfer_reg == `FPRF_CREG_CSR;
  // a denormal result traps as unimplemented unless flushing is on
  assign eff_cause = op_cause |
                     {op_denorm && !cs_r[`FPRF_CSR_FZ_BIT], 5'h00};
  assign op_trap   = eff_cause[`FPRF_CND_E] ||
                     |(eff_cause[4:0] & cs_r[`FPRF_CSR_EN_LSB +: 5]);

  // a flag set by an op wins over a software clear in the same cycle
  always_comb begin
    cs_nxt = cs_r;
    if (csr_wr)
      cs_nxt = xfer_wdata[31:0];
    if (op_valid) begin
      cs_nxt[`FPRF_CSR_CAU_LSB +: 6] = eff_cause;
      if (!op_trap)
        cs_nxt[`FPRF_CSR_FLAG_LSB +: 5] = cs_nxt[`FPRF_CSR_FLAG_LSB +: 5] |
                                          eff_cause[4:0];
    end
    if (cmp_valid) begin
      if (cmp_cc == 3'h0)
        cs_nxt[`FPRF_CSR_CC0_BIT] = cmp_true;
      else
        cs_nxt[`FPRF_CSR_CCH_LSB + int'(cmp_cc) - 1] = cmp_true;
    end
  end

  // reset value is a convenience; software still initialises it
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      cs_r <= `FPRF_CSR_RST;
    else
      cs_r <= cs_nxt;
  end

  // trap is a level that holds until software or the next op's cause rewrite clears the enabled causes
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      trap_r <= 1'b0;
    else
      trap_r <= cs_nxt[`FPRF_CSR_CAU_LSB + `FPRF_CND_E] ||
                |(cs_nxt[`FPRF_CSR_CAU_LSB +: 5] & cs_nxt[`FPRF_CSR_EN_LSB +: 5]);
  end

  // mode outputs to the arithmetic datapath
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flush_to_zero_r   <= 1'b0;
      rounding_select_r <= fprf_pkg::FPRF_RND_NEAR;
    end else begin
      flush_to_zero_r   <= cs_nxt[`FPRF_CSR_FZ_BIT];
      rounding_select_r <= fprf_pkg::fprf_round_t'(cs_nxt[`FPRF_CSR_RND_LSB +: 2]);
    end
  end

  // branch test reads the settled condition bits
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      br_taken_r <= 1'b0;
    else
      br_taken_r <= (br_cc == 3'h0) ? cs_r[`FPRF_CSR_CC0_BIT] :
                    cs_r[`FPRF_CSR_CCH_LSB + int'(br_cc) - 1];
  end

  // ****************************************************************
  //  read side of the transfer port
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      xfer_rdata_r   <= 64'h0000_0000_0000_0000;
      xfer_done_r    <= 1'b0;
      xfer_illegal_r <= 1'b0;
    end else begin
      xfer_done_r    <= xfer_valid && !x_bad;
      xfer_illegal_r <= xfer_valid && x_bad;
      if (xfer_valid && !x_bad && x_rd) begin
        if (x_ct && xfer_reg == `FPRF_CREG_ID)
          xfer_rdata_r <= {48'h0000_0000_0000, IMPL_ID, REV_ID};
        else if (x_ct)
          xfer_rdata_r <= {32'h0000_0000, cs_r};
        else if (x_dw && !m64)
          xfer_rdata_r <= {gr_r[x_odd][31:0], gr_r[x_even][31:0]};
        else if (x_dw)
          xfer_rdata_r <= gr_r[xfer_reg];
        else
          xfer_rdata_r <= {32'h0000_0000, gr_r[xfer_reg][31:0]};
      end
    end
  end

  // ****************************************************************
  //  checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  trap_level_a: assert property (
    trap_r == (cs_r[`FPRF_CSR_CAU_LSB + `FPRF_CND_E] ||
               |(cs_r[`FPRF_CSR_CAU_LSB +: 5] & cs_r[`FPRF_CSR_EN_LSB +: 5])))
    else $error("trap level does not match cause and enable");

  unimpl_trap_a: assert property (
    cs_r[`FPRF_CSR_CAU_LSB + `FPRF_CND_E] |-> trap_r)
    else $error("unimplemented cause without trap");

  flag_sticky_a: assert property (
    !$past(csr_wr) |-> (($past(cs_r[`FPRF_CSR_FLAG_LSB +: 5]) &
                         ~cs_r[`FPRF_CSR_FLAG_LSB +: 5]) == 5'h00))
    else $error("flag cleared without software write");

  cause_rewrite_a: assert property (
    op_valid |=> cs_r[`FPRF_CSR_CAU_LSB +: 6] == $past(eff_cause))
    else $error("cause field not rewritten by operation");

  csr_write_a: assert property (
    csr_wr && !op_valid && !cmp_valid |=> cs_r == $past(xfer_wdata[31:0]))
    else $error("control/status write lost");

  word_back_a: assert property (
    (x_wr && !x_dw && !op_valid) ##1
    (xfer_valid && xfer_op == fprf_pkg::FPRF_ST_W && xfer_reg == $past(xfer_reg))
    |=> xfer_rdata_r[31:0] == $past(xfer_wdata[31:0], 2))
    else $error("store word differs from loaded word");

  pair_order_a: assert property (
    x_wr && x_dw && !m64 && !op_valid |=>
    gr_r[$past(x_even)][31:0] == $past(xfer_wdata[31:0]) &&
    gr_r[$past(x_odd)][31:0] == $past(xfer_wdata[63:32]))
    else $error("doubleword pair written in wrong order");

  level_gate_a: assert property (
    xfer_valid && x_dw && (LEVEL < 2 || (x_mv && !m64)) |=> xfer_illegal_r && !xfer_done_r)
    else $error("64-bit transfer accepted at this level");

  load_tag_a: assert property (
    x_wr && !op_valid |=> tag_r[$past(x_tix)] == fprf_pkg::FPRF_UNINT)
    else $error("loaded operand register not uninterpreted");

  unknown_out_a: assert property (
    op_valid && res_unk |=> res_unknown_r && tag_r[$past(wp_idx)] == fprf_pkg::FPRF_UNKN)
    else $error("mismatched source did not give unknown result");

  round_out_a: assert property (
    rounding_select_r == fprf_pkg::fprf_round_t'(cs_r[`FPRF_CSR_RND_LSB +: 2]))
    else $error("rounding select differs from control field");

endmodule

// file: hdl/fprf_regs.svh
`ifndef FPRF_REGS_SVH
`define FPRF_REGS_SVH
// control register numbers on the transfer port
`define FPRF_CREG_ID      5'h00
`define FPRF_CREG_CSR     5'h1f
// identification field positions
`define FPRF_ID_REV_LSB   0
`define FPRF_ID_IMPL_LSB  8
// control/status field positions
`define FPRF_CSR_RND_LSB  0
`define FPRF_CSR_FLAG_LSB 2
`define FPRF_CSR_EN_LSB   7
`define FPRF_CSR_CAU_LSB  12
`define FPRF_CSR_CC0_BIT  23
`define FPRF_CSR_FZ_BIT   24
`define FPRF_CSR_CCH_LSB  25
// cause bit order inside a 6-bit condition vector
`define FPRF_CND_E        5
// reset values
`define FPRF_CSR_RST      32'h0000_0000
`endif

// file: hdl/fprf_pkg.sv
package fprf_pkg;
  // transfer opcode: bit3 control, bit2 move, bit1 doubleword, bit0 read
  typedef enum logic [3:0] {
    FPRF_LD_W = 4'b0000,
    FPRF_ST_W = 4'b0001,
    FPRF_LD_D = 4'b0010,
    FPRF_ST_D = 4'b0011,
    FPRF_MT_W = 4'b0100,
    FPRF_MF_W = 4'b0101,
    FPRF_MT_D = 4'b0110,
    FPRF_MF_D = 4'b0111,
    FPRF_CT_W = 4'b1000,
    FPRF_CF_W = 4'b1001
  } fprf_xop_t;
  // format held by an operand register
  typedef enum logic [2:0] {
    FPRF_UNINT = 3'b000,
    FPRF_UNKN  = 3'b001,
    FPRF_FMT_S = 3'b010,
    FPRF_FMT_D = 3'b011,
    FPRF_FMT_W = 3'b100,
    FPRF_FMT_L = 3'b101
  } fprf_tag_t;
  typedef enum logic [1:0] {
    FPRF_RND_NEAR = 2'b00,
    FPRF_RND_ZERO = 2'b01,
    FPRF_RND_PLUS = 2'b10,
    FPRF_RND_MINUS = 2'b11
  } fprf_round_t;
endpackage

// file: sim/fprf_core_model.sv
`timescale 1ns/1ps
// ****
// integer core issuing coprocessor transfers
// ****
module fprf_core_model (
  input  wire logic           sys_clk,
  output logic                xfer_valid,
  output fprf_pkg::fprf_xop_t xfer_op,
  output logic [4:0]          xfer_reg,
  output logic [63:0]         xfer_wdata
);
  // quiet port at time zero, nothing requested before reset release
  initial begin
    xfer_valid = 1'b0;
    xfer_op = fprf_pkg::FPRF_LD_W;
    xfer_reg = 5'h00;
    xfer_wdata = 64'h0;
  end
  // drop the request; the data line shows a fresh pattern, not the stale word
  task automatic idle();
    @(posedge sys_clk);
    xfer_valid <= 1'b0;
    xfer_wdata <= ~xfer_wdata;
  endtask
  // one request per edge; slow inserts an idle cycle so both paces occur
  task automatic send(input fprf_pkg::fprf_xop_t op, input logic [4:0] r,
                      input logic [63:0] d, input logic slow);
    if (slow) idle();
    @(posedge sys_clk);
    xfer_valid <= 1'b1;
    xfer_op <= op;
    xfer_reg <= r;
    xfer_wdata <= d;
  endtask
endmodule

// file: sim/fpu_register_file_and_fp_control_status_bench.sv
`timescale 1ns/1ps
// ****
// bench for the register file and control/status block
// ****
module fpu_register_file_and_fp_control_status_bench;
  typedef struct packed {logic ill; logic chk; logic [63:0] d;} fprf_note_t;
  localparam logic [7:0] IMPL = 8'h3c; // arbitrary value
  localparam logic [7:0] REV  = 8'h07; // arbitrary value
  logic                  sys_clk, nrst, model64_sel, xfer_valid, op_valid, op_src_b_used;
  logic                  op_denorm, cmp_valid, cmp_true, xfer_done_r, xfer_illegal_r;
  logic                  trap_r, flush_to_zero_r, res_unknown_r, br_taken_r;
  logic [2:0]            cmp_cc, br_cc;
  logic [4:0]            xfer_reg, op_src_a, op_src_b, op_dst;
  logic [5:0]            op_cause;
  logic [31:0]           seed, v;
  logic [63:0]           xfer_wdata, op_result, xfer_rdata_r, x, mem[32];
  fprf_pkg::fprf_xop_t   xfer_op;
  fprf_pkg::fprf_tag_t   op_src_fmt, op_res_fmt;
  fprf_pkg::fprf_round_t rounding_select_r;
  fprf_note_t            notes[$];
  fprf_note_t            nt;
  int                    n_errors, n_tests;

  fprf_top #(.IMPL_ID(IMPL), .REV_ID(REV)) fprf_top_inst (.sys_clk, .nrst, .model64_sel,
    .xfer_valid, .xfer_op, .xfer_reg, .xfer_wdata, .op_valid, .op_src_fmt, .op_res_fmt,
    .op_src_a, .op_src_b, .op_src_b_used, .op_dst, .op_result, .op_cause, .op_denorm,
    .cmp_valid, .cmp_cc, .cmp_true, .br_cc, .xfer_rdata_r, .xfer_done_r, .xfer_illegal_r,
    .trap_r, .flush_to_zero_r, .rounding_select_r, .res_unknown_r, .br_taken_r);
  fprf_core_model fprf_core_model_inst (.sys_clk, .xfer_valid, .xfer_op, .xfer_reg,
    .xfer_wdata);

  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] rnd();
    seed = lfsr(lfsr(seed));
    return {seed, lfsr(seed)};
  endfunction
  // control/status image: cause, enables, flags, rounding 0
  function automatic logic [63:0] csr(input logic [5:0] c, input logic [4:0] fl, en);
    return 64'({c, en, fl, 2'b00});
  endfunction
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // note the expectation first, since the answer may come one edge later
  task automatic xf(input fprf_pkg::fprf_xop_t op, input logic [4:0] r,
                    input logic [63:0] d, input logic ill, c, input logic [63:0] e);
    notes.push_back('{ill, c, e});
    fprf_core_model_inst.send(op, r, d, seed[3]);
    seed = lfsr(seed);
  endtask
  task automatic wr(input fprf_pkg::fprf_xop_t op, input logic [4:0] r, input logic [63:0] d);
    xf(op, r, d, 1'b0, 1'b0, 64'h0);
  endtask
  task automatic rd(input fprf_pkg::fprf_xop_t op, input logic [4:0] r, input logic [63:0] e);
    xf(op, r, 64'h0, 1'b0, 1'b1, e);
  endtask
  task automatic no(input fprf_pkg::fprf_xop_t op, input logic [4:0] r);
    xf(op, r, 64'h0, 1'b1, 1'b0, 64'h0);
  endtask
  // ops must never share an edge with a transfer, so the port goes quiet first
  task automatic drain();
    fprf_core_model_inst.idle();
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic op(input fprf_pkg::fprf_tag_t f, input logic [4:0] a, b, d,
                    input logic [5:0] c, input logic dn, un);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_src_fmt <= f;
    op_res_fmt <= f;
    op_src_a <= a;
    op_src_b <= b;
    op_src_b_used <= (a != b);
    op_dst <= d;
    op_result <= rnd();
    op_cause <= c;
    op_denorm <= dn;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    #1 chk("unknown result", 64'(un), 64'(res_unknown_r));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****
  // clock, watchdog and answer monitor
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // the run needs well under a thousand cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  // each answer pulse consumes the oldest note
  always @(posedge sys_clk) begin
    if (xfer_done_r === 1'b1 || xfer_illegal_r === 1'b1) begin
      if (notes.size() == 0) chk("spare answer", 64'h0, 64'h1);
      else begin
        nt = notes.pop_front();
        chk("refused", 64'(nt.ill), 64'(xfer_illegal_r));
        if (nt.chk) chk("read data", nt.d, xfer_rdata_r);
      end
    end
  end

  // ****
  // scenarios
  // ****
  initial begin
    {nrst, model64_sel, op_valid, op_src_b_used, op_denorm, cmp_valid, cmp_true} = 7'h00;
    {cmp_cc, br_cc, op_src_a, op_src_b, op_dst, op_cause} = 27'h000_0000;
    op_result = 64'h0;
    op_src_fmt = fprf_pkg::FPRF_FMT_S;
    op_res_fmt = fprf_pkg::FPRF_FMT_S;
    {seed, n_errors, n_tests} = {32'h5259, 64'h0};
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    chk("trap", 64'h0, 64'(trap_r));
    rd(fprf_pkg::FPRF_CF_W, 5'd31, 64'h0);
    rd(fprf_pkg::FPRF_CF_W, 5'd0, {48'h0000_0000_0000, IMPL, REV});
    $display("test reset done");
    for (int r = 0; r < 32; r++) begin
      mem[r] = rnd();
      wr(fprf_pkg::FPRF_LD_W, r[4:0], mem[r]);
    end
    for (int r = 0; r < 32; r++) begin
      x = {32'h0000_0000, mem[r][31:0]};
      rd(r[0] ? fprf_pkg::FPRF_MF_W : fprf_pkg::FPRF_ST_W, r[4:0], x);
    end
    x = rnd();
    wr(fprf_pkg::FPRF_LD_D, 5'd4, x);
    rd(fprf_pkg::FPRF_ST_W, 5'd4, {32'h0000_0000, x[31:0]});
    rd(fprf_pkg::FPRF_ST_W, 5'd5, {32'h0000_0000, x[63:32]});
    rd(fprf_pkg::FPRF_ST_D, 5'd4, x);
    no(fprf_pkg::FPRF_LD_D, 5'd5);
    no(fprf_pkg::FPRF_MT_D, 5'd4);
    no(fprf_pkg::fprf_xop_t'(4'ha), 5'd0);
    no(fprf_pkg::FPRF_CT_W, 5'd5);
    wr(fprf_pkg::FPRF_CT_W, 5'd0, rnd());
    rd(fprf_pkg::FPRF_CF_W, 5'd0, {48'h0000_0000_0000, IMPL, REV});
    // load then store on consecutive edges, no idle cycle between them
    x = rnd();
    notes.push_back('{1'b0, 1'b0, 64'h0});
    fprf_core_model_inst.send(fprf_pkg::FPRF_LD_W, 5'd11, x, 1'b0);
    notes.push_back('{1'b0, 1'b1, {32'h0000_0000, x[31:0]}});
    fprf_core_model_inst.send(fprf_pkg::FPRF_ST_W, 5'd11, 64'h0, 1'b0);
    $display("test 32-bit model done");
    drain();
    @(posedge sys_clk) model64_sel <= 1'b1;
    x = rnd();
    v = seed;
    wr(fprf_pkg::FPRF_MT_D, 5'd7, x);
    rd(fprf_pkg::FPRF_MF_D, 5'd7, x);
    wr(fprf_pkg::FPRF_MT_W, 5'd7, {32'h0000_0000, v});
    rd(fprf_pkg::FPRF_MF_D, 5'd7, {x[63:32], v});
    rd(fprf_pkg::FPRF_ST_W, 5'd7, {32'h0000_0000, v});
    wr(fprf_pkg::FPRF_LD_D, 5'd2, rnd());
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd2, 5'd2, 5'd6, 6'h00, 1'b0, 1'b0);
    op(fprf_pkg::FPRF_FMT_D, 5'd2, 5'd2, 5'd6, 6'h00, 1'b0, 1'b1);
    op(fprf_pkg::FPRF_FMT_S, 5'd3, 5'd2, 5'd8, 6'h00, 1'b0, 1'b1);
    op(fprf_pkg::FPRF_FMT_D, 5'd9, 5'd9, 5'd9, 6'h00, 1'b0, 1'b0);
    rd(fprf_pkg::FPRF_ST_D, 5'd9, op_result);
    $display("test 64-bit model done");
    for (int i = 0; i < 8; i++) begin
      v = seed & 32'hff83_ffff;
      seed = lfsr(seed);
      v[1:0] = i[1:0];
      wr(fprf_pkg::FPRF_CT_W, 5'd31, {32'h0000_0000, v});
      rd(fprf_pkg::FPRF_CF_W, 5'd31, {32'h0000_0000, v});
      drain();
      chk("rounding", 64'(v[1:0]), 64'(rounding_select_r));
      chk("flush", 64'(v[24]), 64'(flush_to_zero_r));
      chk("trap", 64'(v[17] | (|(v[16:12] & v[11:7]))), 64'(trap_r));
    end
    $display("test control/status done");
    wr(fprf_pkg::FPRF_CT_W, 5'd31, 64'h0);
    for (int k = 0; k < 8; k++) begin
      drain();
      cmp_valid <= 1'b1;
      cmp_cc <= k[2:0];
      cmp_true <= seed[k];
      br_cc <= k[2:0];
      @(posedge sys_clk);
      cmp_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk("branch", 64'(seed[k]), 64'(br_taken_r));
    end
    rd(fprf_pkg::FPRF_CF_W, 5'd31, 64'({seed[7:1], 1'b0, seed[0], 23'h00_0000}));
    wr(fprf_pkg::FPRF_CT_W, 5'd31, 64'h0);
    wr(fprf_pkg::FPRF_LD_W, 5'd10, rnd());
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h05, 1'b0, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, csr(6'h05, 5'h05, 5'h00));
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h10, 1'b0, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, csr(6'h10, 5'h15, 5'h00));
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h00, 1'b0, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, csr(6'h00, 5'h15, 5'h00));
    wr(fprf_pkg::FPRF_CT_W, 5'd31, csr(6'h00, 5'h15, 5'h10));
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h10, 1'b0, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, csr(6'h10, 5'h15, 5'h10));
    drain();
    chk("trap", 64'h1, 64'(trap_r));
    wr(fprf_pkg::FPRF_CT_W, 5'd31, csr(6'h00, 5'h15, 5'h00));
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h00, 1'b1, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, csr(6'h20, 5'h15, 5'h00));
    drain();
    chk("trap", 64'h1, 64'(trap_r));
    x = csr(6'h00, 5'h15, 5'h00) | 64'h0100_0000;
    wr(fprf_pkg::FPRF_CT_W, 5'd31, x);
    drain();
    op(fprf_pkg::FPRF_FMT_S, 5'd10, 5'd10, 5'd10, 6'h00, 1'b1, 1'b0);
    rd(fprf_pkg::FPRF_CF_W, 5'd31, x);
    rd(fprf_pkg::FPRF_ST_W, 5'd10, 64'h0);
    drain();
    chk("trap", 64'h0, 64'(trap_r));
    $display("test operations done");
    repeat (4) @(posedge sys_clk);
    if (notes.size() != 0) n_errors++;
    summarize();
  end
endmodule
